/* File: common/clid_regs.vh */
// Constants for the character display instruction decoder
`ifndef CLID_REGS_VH
`define CLID_REGS_VH
// ******************************
// Instruction field positions
// ******************************
`define CLID_BIT_CLEAR 0
`define CLID_BIT_HOME 1
`define CLID_BIT_ENTRY 2
`define CLID_BIT_ONOFF 3
`define CLID_BIT_SHIFT 4
`define CLID_BIT_FUNC 5
`define CLID_BIT_GLYPH 6
`define CLID_BIT_TEXT 7
`define CLID_BIT_BW 4
`define CLID_BIT_LINES 3
`define CLID_BIT_EXT 2
`define CLID_BIT_SC 3
`define CLID_BIT_RL 2
// ******************************
// Reset and fill values, RAM depths and line layout
// ******************************
`define CLID_SPACE_CODE 8'h20
`define CLID_ADDR_HOME 7'h00
`define CLID_TEXT_DEPTH 128
`define CLID_GLYPH_DEPTH 64
`define CLID_LINE_LEN 7'h28
`define CLID_LINE2_BASE 7'h40
`define CLID_LINE2_END 7'h67
`define CLID_ONE_LINE_END 7'h4f
`define CLID_LEN_RESET 7'h4f
// ******************************
// Timing
// ******************************
`define CLID_CLK_HZ 125000000
`define CLID_CLEAR_NS 1520000
`define CLID_INSTR_NS 37000
`define CLID_CLEAR_CYC ((`CLID_CLEAR_NS * 125) / 1000)
`define CLID_INSTR_CYC ((`CLID_INSTR_NS * 125) / 1000)
`define CLID_BLINK_CYC 32'd50000000
`endif

/* File: verilog/clid_decoder.v */
// Instruction decoder of a character display controller
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clid_regs.vh"
module clid_decoder #(
    parameter CLEAR_CYC = `CLID_CLEAR_CYC,
    parameter INSTR_CYC = `CLID_INSTR_CYC,
    parameter BLINK_CYC = `CLID_BLINK_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Host access, one cycle strobes
    input wire register_select,
    input wire [7:0] wr_data,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rd_data,
    // Mode and status
    output wire busy_indicator,
    output reg [6:0] address_pointer,
    output reg instr_set_select,
    output reg bus_width_sel,
    output reg two_line,
    output reg display_on,
    output reg cursor_on,
    output reg blink_on,
    output reg step_inc,
    output reg auto_display_shift,
    output reg glyph_sel,
    output reg [6:0] shift_offset,
    output reg bias_res_sel_hi,
    output reg bias_res_sel_lo,
    output reg common_low_reverse,
    output reg common_high_reverse,
    output reg segment_low_reverse,
    output reg segment_high_reverse,
    output reg [6:0] data_length_field,
    // Display read port
    input wire [6:0] disp_addr,
    output reg [7:0] disp_char
);
    // ******************************
    // Storage
    // ******************************
    reg [7:0] text_ram [0:`CLID_TEXT_DEPTH-1];
    reg [7:0] glyph_ram [0:`CLID_GLYPH_DEPTH-1];
    reg [31:0] busy_cnt_reg;
    reg [31:0] blink_cnt_reg;
    reg blink_phase_reg;
    reg [7:0] out_data_reg;
    reg nib_half_reg;
    reg [3:0] nib_hi_reg;
    reg clearing_reg;
    reg [6:0] clear_idx_reg;

    assign busy_indicator = (busy_cnt_reg != 32'd0);

    // ******************************
    // Nibble assembly
    // ******************************
    // assemble nibble pairs
    wire byte_wr = wr_stb & (bus_width_sel | nib_half_reg);
    wire byte_rd = rd_stb & (bus_width_sel | nib_half_reg);
    wire [7:0] cmd = bus_width_sel ? wr_data : {nib_hi_reg, wr_data[7:4]};
    // The phase flips on every strobe, busy or not; a host that loses step
    // must realign by sending extra nibbles, since a stray one skews every byte

    // ******************************
    // Read path
    // ******************************
    reg [7:0] rd_byte;
    always @* begin
        if (register_select)
            rd_byte = out_data_reg;
        else
            rd_byte = {busy_indicator, address_pointer};
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nib_half_reg <= 1'b0;
            nib_hi_reg <= 4'h0;
            rd_data <= 8'h00;
        end else begin
            if (bus_width_sel) begin
                nib_half_reg <= 1'b0;
                if (rd_stb)
                    rd_data <= rd_byte;
            end else if (wr_stb | rd_stb) begin
                nib_half_reg <= ~nib_half_reg;
                if (wr_stb && !nib_half_reg)
                    nib_hi_reg <= wr_data[7:4];
                if (rd_stb)
                    rd_data <= nib_half_reg ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0};
            end
        end
    end

    // ******************************
    // Decode
    // ******************************
    // Nothing decodes while busy or during the clear walk; such writes are lost
    wire ins = byte_wr & ~register_select & ~busy_indicator & ~clearing_reg;
    wire is_clear = ins && cmd == 8'h01;
    wire is_home = ins && cmd[7:1] == 7'h01;
    wire is_onoff = ins && cmd[7:3] == 5'h01;
    wire is_shift = ins && cmd[7:4] == 4'h1;
    wire is_func = ins && cmd[7:5] == 3'h1;
    wire is_entry = ins && !instr_set_select && cmd[7:2] == 6'h01;
    wire is_glyph = ins && !instr_set_select && cmd[7:6] == 2'h1;
    wire is_text = ins && !instr_set_select && cmd[7];
    wire is_bias = ins && instr_set_select && cmd[7:2] == 6'h01;
    // The scan code shares 00001xxx with the common on/off code, so in the
    // extended set both act; the high commons flag needs bit 2 clear and so
    // can only be cleared, a known limit of this encoding
    wire is_scan = ins && instr_set_select && cmd[7:4] == 4'h0 && cmd[3] && !cmd[2];
    wire is_len = ins && instr_set_select && cmd[7];
    wire dat_wr = byte_wr & register_select & ~busy_indicator & ~clearing_reg;
    wire dat_rd = byte_rd & register_select & ~busy_indicator & ~clearing_reg;
    wire ran_37 = is_onoff | is_shift | is_func | is_entry | is_glyph | is_text
        | is_bias | is_scan | is_len | dat_wr | dat_rd;

    // Step the pointer honouring line layout
    function [6:0] step_addr;
        input [6:0] a;
        input up;
        input glyph;
        input lines2;
        begin
            if (glyph)
                step_addr = up ? {1'b0, a[5:0] + 6'd1} : {1'b0, a[5:0] - 6'd1};
            else if (!lines2)
                step_addr = up ? ((a >= `CLID_ONE_LINE_END) ? 7'h00 : a + 7'd1)
                    : ((a == 7'h00) ? `CLID_ONE_LINE_END : a - 7'd1);
            else if (up)
                step_addr = (a == `CLID_LINE_LEN - 7'd1) ? `CLID_LINE2_BASE
                    : (a >= `CLID_LINE2_END) ? 7'h00 : a + 7'd1;
            else
                step_addr = (a == `CLID_LINE2_BASE) ? `CLID_LINE_LEN - 7'd1
                    : (a == 7'h00) ? `CLID_LINE2_END : a - 7'd1;
        end
    endfunction

    // ******************************
    // Pointer stepping
    // ******************************
    // Next address of a data access, in the entry direction
    wire [6:0] data_next = step_addr(address_pointer, step_inc, glyph_sel, two_line);
    // Next address of a cursor shift, in the shift direction
    wire [6:0] cursor_next = step_addr(address_pointer, cmd[`CLID_BIT_RL], glyph_sel,
        two_line);
    // A cursor shift preloads from text RAM, whichever RAM is selected
    wire [6:0] cursor_text = step_addr(address_pointer, cmd[`CLID_BIT_RL], 1'b0, two_line);

    // ******************************
    // Busy timing
    // ******************************
    // Busy ends on its own count; a refused write never restarts it
    // busy timing
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= 32'd0;
        end else if (busy_cnt_reg != 32'd0) begin
            busy_cnt_reg <= busy_cnt_reg - 32'd1;
        end else if (is_clear) begin
            busy_cnt_reg <= CLEAR_CYC;
        end else if (ran_37) begin
            busy_cnt_reg <= INSTR_CYC;
        end
    end

    // ******************************
    // Clear fill sequencer
    // ******************************
    // Walks every text location once, one per cycle, well inside the busy span
    // fill with spaces
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clearing_reg <= 1'b0;
            clear_idx_reg <= 7'h00;
        end else if (is_clear) begin
            clearing_reg <= 1'b1;
            clear_idx_reg <= 7'h00;
        end else if (clearing_reg) begin
            clear_idx_reg <= clear_idx_reg + 7'd1;
            if (clear_idx_reg == 7'h7f)
                clearing_reg <= 1'b0;
        end
    end

    // ******************************
    // State update
    // ******************************
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            address_pointer <= `CLID_ADDR_HOME;
            instr_set_select <= 1'b0;
            bus_width_sel <= 1'b1;
            two_line <= 1'b0;
            display_on <= 1'b0;
            cursor_on <= 1'b0;
            blink_on <= 1'b0;
            step_inc <= 1'b1;
            auto_display_shift <= 1'b0;
            glyph_sel <= 1'b0;
            shift_offset <= 7'h00;
            bias_res_sel_hi <= 1'b0;
            bias_res_sel_lo <= 1'b0;
            common_low_reverse <= 1'b0;
            common_high_reverse <= 1'b0;
            segment_low_reverse <= 1'b0;
            segment_high_reverse <= 1'b0;
            data_length_field <= `CLID_LEN_RESET;
            out_data_reg <= 8'h00;
        end else begin
            if (is_clear) begin
                address_pointer <= `CLID_ADDR_HOME;
                shift_offset <= 7'h00;
                step_inc <= 1'b1;
                glyph_sel <= 1'b0;
            end
            if (is_home) begin
                address_pointer <= `CLID_ADDR_HOME;
                shift_offset <= 7'h00;
                glyph_sel <= 1'b0;
            end
            if (is_onoff) begin
                display_on <= cmd[2];
                cursor_on <= cmd[1];
                blink_on <= cmd[0];
            end
            if (is_shift) begin
                if (!cmd[`CLID_BIT_SC]) begin
                    address_pointer <= cursor_next;
                    out_data_reg <= text_ram[cursor_text];
                end else begin
                    shift_offset <= cmd[`CLID_BIT_RL] ? shift_offset + 7'd1
                        : shift_offset - 7'd1;
                end
            end
            if (is_func) begin
                bus_width_sel <= cmd[`CLID_BIT_BW];
                two_line <= cmd[`CLID_BIT_LINES];
                instr_set_select <= cmd[`CLID_BIT_EXT];
            end
            if (is_entry) begin
                step_inc <= cmd[1];
                auto_display_shift <= cmd[0];
            end
            if (is_glyph) begin
                address_pointer <= {1'b0, cmd[5:0]};
                glyph_sel <= 1'b1;
                out_data_reg <= glyph_ram[cmd[5:0]];
            end
            if (is_text) begin
                address_pointer <= cmd[6:0];
                glyph_sel <= 1'b0;
                out_data_reg <= text_ram[cmd[6:0]];
            end
            if (is_bias) begin
                bias_res_sel_hi <= cmd[1];
                bias_res_sel_lo <= cmd[0];
            end
            if (is_scan) begin
                common_low_reverse <= cmd[3];
                common_high_reverse <= cmd[2];
                segment_low_reverse <= cmd[1];
                segment_high_reverse <= cmd[0];
            end
            if (is_len)
                data_length_field <= cmd[6:0];
            if (dat_wr) begin
                address_pointer <= data_next;
                // auto shift on text write
                // A left shift lowers the offset, the inverse of a right display shift
                if (auto_display_shift && !glyph_sel)
                    shift_offset <= step_inc ? shift_offset - 7'd1 : shift_offset + 7'd1;
            end
            // read returns output then steps
            // The output register holds the word due next, so a read answers
            // from it and refills it from the stepped address
            if (dat_rd) begin
                address_pointer <= data_next;
                out_data_reg <= glyph_sel ? glyph_ram[data_next[5:0]]
                    : text_ram[data_next];
            end
        end
    end

    // ******************************
    // RAM writes, no reset on arrays
    // ******************************
    // The clear walk owns the text port; writes that arrive during it are refused, not held
    always @(posedge mclk) begin
        if (clearing_reg)
            text_ram[clear_idx_reg] <= `CLID_SPACE_CODE;
        else if (dat_wr && !glyph_sel)
            text_ram[address_pointer] <= cmd;
        if (dat_wr && glyph_sel)
            glyph_ram[address_pointer[5:0]] <= cmd;
    end

    // ******************************
    // Blink and display output
    // ******************************
    // One-cycle enable from the blink divider; the cursor phase flips on each
    wire blink_tick = (blink_cnt_reg >= BLINK_CYC - 32'd1);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_reg <= 32'd0;
            blink_phase_reg <= 1'b0;
            disp_char <= 8'h00;
        end else begin
            if (blink_tick) begin
                blink_cnt_reg <= 32'd0;
                blink_phase_reg <= ~blink_phase_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 32'd1;
            end
            if (!display_on)
                disp_char <= `CLID_SPACE_CODE;
            else if (blink_on && blink_phase_reg && disp_addr == address_pointer && !glyph_sel)
                disp_char <= 8'hff;
            else
                disp_char <= text_ram[disp_addr + shift_offset];
        end
    end
endmodule
`default_nettype wire

/* File: tb/clid_checker_assertions.sv */
// Port checker for the display instruction decoder
`timescale 1ns/1ps
`default_nettype none
module clid_checker #(
    parameter CLEAR_CYC = 8,
    parameter INSTR_CYC = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Host access
    input wire logic register_select,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    // Mode and status
    input wire logic busy_indicator,
    input wire logic [6:0] address_pointer,
    input wire logic instr_set_select,
    input wire logic bus_width_sel,
    input wire logic two_line,
    input wire logic step_inc,
    input wire logic glyph_sel,
    input wire logic [6:0] shift_offset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [31:0] run_reg;
    // Only whole bytes in 8-bit mode while idle count as accepted
    wire cmd_ok = wr_stb && !register_select && !busy_indicator && bus_width_sel;
    wire basic_ok = cmd_ok && !instr_set_select;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 32'h0;
        end else begin
            run_reg <= busy_indicator ? run_reg + 32'h1 : 32'h0;
        end
    end
    sequence s_busy_end;
        busy_indicator ##1 !busy_indicator;
    endsequence
    chk_busy_span:
        assert property (s_busy_end |-> (run_reg == INSTR_CYC || run_reg == CLEAR_CYC))
        else $error("busy span wrong");
    chk_status_read:
        assert property (rd_stb && !register_select && bus_width_sel |=>
            rd_data == {$past(busy_indicator), $past(address_pointer)})
        else $error("status read wrong");
    chk_clear_state:
        assert property (cmd_ok && wr_data == 8'h01 |=>
            address_pointer == 7'h00 && step_inc && busy_indicator)
        else $error("clear state wrong");
    chk_home_zero:
        assert property (cmd_ok && wr_data[7:1] == 7'h01 |=>
            address_pointer == 7'h00 && shift_offset == 7'h00)
        else $error("home state wrong");
    chk_glyph_load:
        assert property (basic_ok && wr_data[7:6] == 2'b01 |=>
            glyph_sel && address_pointer == {1'b0, $past(wr_data[5:0])})
        else $error("glyph address wrong");
    chk_text_load:
        assert property (basic_ok && wr_data[7] |=>
            !glyph_sel && address_pointer == $past(wr_data[6:0]))
        else $error("text address wrong");
    chk_func_latch:
        assert property (cmd_ok && wr_data[7:5] == 3'b001 |=>
            {bus_width_sel, two_line, instr_set_select} == $past(wr_data[4:2]))
        else $error("function set wrong");
    chk_ext_ignore:
        assert property (cmd_ok && instr_set_select && wr_data[7:6] == 2'b01 |=>
            !busy_indicator && $stable(address_pointer) && $stable(glyph_sel))
        else $error("inactive set acted");
endmodule
bind clid_decoder clid_checker #(.CLEAR_CYC(CLEAR_CYC), .INSTR_CYC(INSTR_CYC)) chk_u (
    .mclk, .rst_n, .register_select, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .busy_indicator, .address_pointer, .instr_set_select, .bus_width_sel,
    .two_line, .step_inc, .glyph_sel, .shift_offset);
`default_nettype wire

/* File: tb/clid_host.sv */
// Host model driving the decoder access port
`timescale 1ns/1ps
`default_nettype none
module clid_host (
    // Clock
    input wire logic mclk,
    // Access port
    output logic register_select,
    output logic [7:0] wr_data,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic busy_indicator
);
    initial begin
        register_select = 1'b0;
        wr_data = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_indicator !== 1'b0 && n < 1000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic wr(input logic rs, input logic [7:0] d, input logic poll);
        @(posedge mclk);
        if (poll) wait_idle();
        register_select <= rs;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        // Released bus must not keep showing the byte
        wr_data <= ~d;
        #1;
    endtask
    task automatic rd(input logic rs, output logic [7:0] q);
        @(posedge mclk);
        if (rs) wait_idle();
        register_select <= rs;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 q = rd_data;
    endtask
endmodule
`default_nettype wire

/* File: tb/clid_decoder_tb.sv */
// Self-checking bench for the display instruction decoder
`timescale 1ns/1ps
`default_nettype none
module clid_decoder_tb;
    localparam int CLR = 200;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] disp_addr = 7'h00;
    int fail_count = 0;
    int n_compared = 0;
    wire [7:0] wr_data, rd_data, disp_char;
    wire [6:0] address_pointer, shift_offset, data_length_field;
    wire register_select, wr_stb, rd_stb, busy_indicator, instr_set_select;
    wire bus_width_sel, two_line, display_on, cursor_on, blink_on, step_inc;
    wire auto_display_shift, glyph_sel, bias_res_sel_hi, bias_res_sel_lo;
    wire common_low_reverse, common_high_reverse, segment_low_reverse;
    wire segment_high_reverse;
    always #4 mclk = ~mclk;
    clid_decoder #(.CLEAR_CYC(CLR), .INSTR_CYC(4), .BLINK_CYC(4)) dut_u (
        .mclk, .rst_n, .register_select, .wr_data, .wr_stb, .rd_stb, .rd_data,
        .busy_indicator, .address_pointer, .instr_set_select, .bus_width_sel,
        .two_line, .display_on, .cursor_on, .blink_on, .step_inc,
        .auto_display_shift, .glyph_sel, .shift_offset, .bias_res_sel_hi,
        .bias_res_sel_lo, .common_low_reverse, .common_high_reverse,
        .segment_low_reverse, .segment_high_reverse, .data_length_field,
        .disp_addr, .disp_char);
    clid_host host_u (.mclk, .register_select, .wr_data, .wr_stb, .rd_stb,
        .rd_data, .busy_indicator);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic t_clear;
        logic [7:0] q;
        host_u.wr(0, 8'h85, 1);
        host_u.wr(1, 8'h41, 1);
        host_u.wr(0, 8'h04, 1);
        host_u.wr(0, 8'h01, 1);
        check({busy_indicator, address_pointer}, 8'h80);
        check({7'h0, step_inc}, 8'h01);
        repeat (CLR - 3) @(posedge mclk);
        #1 check({7'h0, busy_indicator}, 8'h01);
        repeat (5) @(posedge mclk);
        #1 check({7'h0, busy_indicator}, 8'h00);
        host_u.wr(0, 8'h85, 1);
        host_u.rd(1, q);
        check(q, 8'h20);
        $display("clear test done");
    endtask
    task automatic t_data;
        logic [7:0] q;
        host_u.wr(0, 8'h06, 1);
        host_u.wr(0, 8'h90, 1);
        host_u.wr(1, 8'h5a, 1);
        host_u.wr(1, 8'h33, 1);
        host_u.rd(0, q);
        check(q, 8'h92);
        host_u.wr(0, 8'h90, 1);
        host_u.rd(1, q);
        check(q, 8'h5a);
        host_u.rd(1, q);
        check(q, 8'h33);
        host_u.wr(0, 8'h04, 1);
        host_u.wr(1, 8'h77, 1);
        check({1'b0, address_pointer}, 8'h11);
        $display("data test done");
    endtask
    task automatic t_onoff;
        int ones;
        @(posedge mclk);
        disp_addr <= 7'h10;
        host_u.wr(0, 8'h0f, 1);
        host_u.wr(0, 8'h08, 0);
        check({5'h0, display_on, cursor_on, blink_on}, 8'h07);
        check(disp_char, 8'h5a);
        host_u.wr(0, 8'h08, 1);
        repeat (3) @(posedge mclk);
        #1 check(disp_char, 8'h20);
        @(posedge mclk);
        disp_addr <= 7'h11;
        host_u.wr(0, 8'h0d, 1);
        ones = 0;
        repeat (8) begin
            @(posedge mclk);
            #1;
            if (disp_char == 8'hff)
                ones++;
            else
                check(disp_char, 8'h33);
        end
        check(ones[7:0], 8'h04);
        $display("on-off test done");
    endtask
    task automatic t_shift;
        host_u.wr(0, 8'h38, 1);
        host_u.wr(0, 8'h90, 1);
        host_u.wr(0, 8'h14, 1);
        check({1'b0, address_pointer}, 8'h11);
        host_u.wr(0, 8'h1c, 1);
        check({1'b0, address_pointer}, 8'h11);
        check({1'b0, shift_offset}, 8'h01);
        host_u.wr(0, 8'ha7, 1);
        host_u.wr(0, 8'h14, 1);
        check({1'b0, address_pointer}, 8'h40);
        host_u.wr(0, 8'h02, 1);
        check({address_pointer, 1'b0} | {1'b0, shift_offset}, 8'h00);
        $display("shift test done");
    endtask
    task automatic t_auto;
        host_u.wr(0, 8'h07, 1);
        check({7'h0, auto_display_shift}, 8'h01);
        host_u.wr(0, 8'h80, 1);
        host_u.wr(1, 8'h41, 1);
        check({1'b0, shift_offset}, 8'h7f);
        host_u.wr(0, 8'h45, 1);
        host_u.wr(1, 8'h1f, 1);
        check({glyph_sel, address_pointer}, 8'h86);
        check({1'b0, shift_offset}, 8'h7f);
        $display("auto shift test done");
    endtask
    task automatic t_ext;
        logic [3:0] rev;
        host_u.wr(0, 8'h3c, 1);
        check({5'h0, bus_width_sel, two_line, instr_set_select}, 8'h07);
        host_u.wr(0, 8'h45, 1);
        check({busy_indicator, address_pointer}, 8'h06);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(0, 8'h04 | i[7:0], 1);
            check({6'h0, bias_res_sel_hi, bias_res_sel_lo}, i[7:0]);
        end
        host_u.wr(0, 8'h85, 1);
        check({1'b0, data_length_field}, 8'h05);
        host_u.wr(0, 8'h0b, 1);
        rev = {common_low_reverse, common_high_reverse,
            segment_low_reverse, segment_high_reverse};
        check({4'h0, rev}, 8'h0b);
        host_u.wr(0, 8'h09, 1);
        rev = {common_low_reverse, common_high_reverse,
            segment_low_reverse, segment_high_reverse};
        check({4'h0, rev}, 8'h09);
        host_u.wr(0, 8'h38, 1);
        host_u.wr(0, 8'h04, 1);
        check({6'h0, bias_res_sel_hi, bias_res_sel_lo}, 8'h03);
        $display("extended test done");
    endtask
    task automatic t_nibble;
        host_u.wr(0, 8'h28, 1);
        check({7'h0, bus_width_sel}, 8'h00);
        host_u.wr(0, 8'h90, 1);
        host_u.wr(0, 8'h30, 1);
        check({1'b0, address_pointer}, 8'h13);
        host_u.wr(0, 8'h30, 1);
        host_u.wr(0, 8'h80, 1);
        check({7'h0, bus_width_sel}, 8'h01);
        $display("nibble test done");
    endtask
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_clear();
        t_data();
        t_onoff();
        t_shift();
        t_auto();
        t_ext();
        t_nibble();
        wrap_up();
    end
endmodule
`default_nettype wire
